//--- design/rod_regs.svh
`ifndef ROD_REGS_SVH
`define ROD_REGS_SVH

// register byte offsets
`define ROD_CTRL 8'h00
`define ROD_STAT 8'h04
`define ROD_TRUN 8'h08
`define ROD_SLOT0 8'h10
`define ROD_IP0 8'h20
`define ROD_TMR0 8'h40

// slot word fields
`define ROD_TY_LSB 0
`define ROD_DEST_BIT 3
`define ROD_IP_LSB 4
`define ROD_TA_LSB 6
`define ROD_CH_LSB 8
`define ROD_RNG_LSB 12
`define ROD_VAL_LSB 16

// reset values
`define ROD_CTRL_RST 1'h0
`define ROD_SLOT_RST 32'h0000_0000
`define ROD_IP_RST 32'h0000_0000

// true-action and command codes
`define ROD_CMD_START 2'h0
`define ROD_CMD_STOP 2'h1
`define ROD_CMD_THIRD 2'h2
`define ROD_TMR_ON 1'h0

// timing
`define ROD_CLK_NS 5
`define ROD_TICK_NS 1000000

`endif

//--- design/rod_pkg.sv
package rod_pkg;

  typedef enum logic [2:0] {
    null_action = 3'b000,
    analog_out_action = 3'b001,
    digital_out_action = 3'b010,
    counter_channel_action = 3'b011,
    pulse_out_action = 3'b100,
    timer_action = 3'b101
  } rod_act_t;

  typedef enum logic {
    st_idle = 1'b0,
    st_run = 1'b1
  } rod_state_t;

endpackage

//--- design/rod_act_if.sv
`timescale 1ns/1ps
interface rod_act_if;
  import rod_pkg::*;
  logic fire;
  rod_act_t kind;
  logic [3:0] chan;
  logic [1:0] cmd;
  logic [15:0] val;
  logic [2:0] range;
  logic remote;
  logic [1:0] ip_sel;
  modport src(output fire, kind, chan, cmd, val, range, remote, ip_sel);
  modport dst(input fire, kind, chan, cmd, val, range, remote, ip_sel);
endinterface

//--- design/rod_slot.sv
`timescale 1ns/1ps
`include "rod_regs.svh"
module rod_slot import rod_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [31:0] cfg,
  input wire logic res,
  rod_act_if.src act
);
  wire [2:0] ty_w = cfg[`ROD_TY_LSB +: 3];
  wire [1:0] ta_w = cfg[`ROD_TA_LSB +: 2];
  logic fire_c;
  logic [1:0] cmd_c;

  // false action is derived from the true action for digital, counter and timer slots; analog and pulse stay quiet
  always_comb
  begin
    fire_c = 1'b0;
    cmd_c = ta_w;
    case (ty_w)
      null_action: fire_c = 1'b0;
      analog_out_action: fire_c = res;
      digital_out_action:
      begin
        fire_c = 1'b1;
        cmd_c = {1'b0, res ? ta_w[0] : ~ta_w[0]};
      end
      counter_channel_action:
      begin
        // reset has no false counterpart
        fire_c = res ? (ta_w != 2'h3) : (ta_w == `ROD_CMD_START || ta_w == `ROD_CMD_STOP);
        cmd_c = res ? ta_w : {1'b0, ~ta_w[0]};
      end
      pulse_out_action: fire_c = res && (ta_w != 2'h3);
      timer_action:
      begin
        fire_c = 1'b1;
        cmd_c = {1'b0, res ^ ta_w[0]};
      end
      default: fire_c = 1'b0;
    endcase
  end

  assign act.fire = fire_c;
  assign act.kind = rod_act_t'(ty_w);
  assign act.cmd = cmd_c;
  assign act.chan = cfg[`ROD_CH_LSB +: 4];
  assign act.val = cfg[`ROD_VAL_LSB +: 16];
  assign act.range = cfg[`ROD_RNG_LSB +: 3];
  assign act.remote = cfg[`ROD_DEST_BIT];
  assign act.ip_sel = cfg[`ROD_IP_LSB +: 2];

  null_quiet_a: assert property (@(posedge core_clk) disable iff (rst)
    ty_w == null_action |-> !fire_c)
    else $error("null slot fired");
  do_invert_a: assert property (@(posedge core_clk) disable iff (rst)
    (ty_w == digital_out_action && !res) |-> cmd_c[0] == ~ta_w[0])
    else $error("digital false level not inverted");
  keep_false_a: assert property (@(posedge core_clk) disable iff (rst)
    ((ty_w == analog_out_action || ty_w == pulse_out_action) && !res) |-> !fire_c)
    else $error("false result changed analog or pulse output");
endmodule

//--- design/rod_top.sv
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "rod_regs.svh"
module rod_top import rod_pkg::*;
#(
  parameter int unsigned TICK_CYC = `ROD_TICK_NS / `ROD_CLK_NS,
  parameter int unsigned N_TMR = 16,
  parameter int unsigned N_IP = 4
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic res_stb,
  input wire logic res_val,
  output logic busy,
  output logic loc_stb,
  output rod_act_t loc_kind,
  output logic [3:0] loc_chan,
  output logic [1:0] loc_cmd,
  output logic [15:0] loc_val,
  output logic [2:0] loc_range,
  output logic net_valid,
  input wire logic net_ready,
  output logic [31:0] net_ip,
  output rod_act_t net_kind,
  output logic [3:0] net_chan,
  output logic [1:0] net_cmd,
  output logic [15:0] net_val,
  output logic [2:0] net_range
);
  localparam int unsigned N_SLOT = 3;

  logic en_q;
  logic [31:0] slot_q [N_SLOT];
  logic [31:0] ip_q [N_IP];
  logic [15:0] tmr_cnt_q [N_TMR];
  logic [N_TMR-1:0] tmr_run_q;
  logic [31:0] tick_cnt_q;
  logic tick_q;
  rod_state_t st_q;
  logic [1:0] idx_q;
  logic res_q;
  logic busy_q;
  logic [31:0] rdata_q;
  logic loc_stb_q;
  rod_act_t loc_kind_q;
  logic [3:0] loc_chan_q;
  logic [1:0] loc_cmd_q;
  logic [15:0] loc_val_q;
  logic [2:0] loc_range_q;
  logic net_valid_q;
  logic [31:0] net_ip_q;
  rod_act_t net_kind_q;
  logic [3:0] net_chan_q;
  logic [1:0] net_cmd_q;
  logic [15:0] net_val_q;
  logic [2:0] net_range_q;

  logic [N_SLOT-1:0] fire_w;
  logic [N_SLOT-1:0] rem_w;
  rod_act_t kind_w [N_SLOT];
  logic [3:0] chan_w [N_SLOT];
  logic [1:0] cmd_w [N_SLOT];
  logic [15:0] val_w [N_SLOT];
  logic [2:0] rng_w [N_SLOT];
  logic [1:0] ips_w [N_SLOT];

  // every slot sees the same latched result
  for (genvar i = 0; i < N_SLOT; i++)
  begin : g_slot
    rod_act_if act();
    rod_slot u_slot (
      .core_clk(core_clk),
      .rst(rst),
      .cfg(slot_q[i]),
      .res(res_q),
      .act(act.src)
    );
    assign fire_w[i] = act.fire;
    assign rem_w[i] = act.remote;
    assign kind_w[i] = act.kind;
    assign chan_w[i] = act.chan;
    assign cmd_w[i] = act.cmd;
    assign val_w[i] = act.val;
    assign rng_w[i] = act.range;
    assign ips_w[i] = act.ip_sel;
  end

  // register decode
  wire wr_ctrl = reg_wr && reg_addr == `ROD_CTRL;
  wire slot_win = reg_addr[7:4] == 4'h1 && reg_addr[3:2] != 2'h3;
  wire ip_win = reg_addr[7:4] == 4'h2;
  wire tmr_win = reg_addr[7:6] == 2'h1;
  wire [1:0] win_idx = reg_addr[3:2];
  wire [3:0] tmr_ridx = reg_addr[5:2];
  wire [31:0] rd_mux =
    reg_addr == `ROD_CTRL ? {31'h0, en_q} :
    reg_addr == `ROD_STAT ? {28'h0, idx_q, res_q, busy_q} :
    reg_addr == `ROD_TRUN ? {{(32 - N_TMR){1'b0}}, tmr_run_q} :
    slot_win ? slot_q[win_idx] :
    ip_win ? ip_q[win_idx] :
    tmr_win ? {16'h0, tmr_cnt_q[tmr_ridx]} :
    32'h0000_0000;

  // sequencing: one slot per cycle, stalled by a pending link command
  wire accept = st_q == st_idle && res_stb && en_q;
  wire stall = net_valid_q && !net_ready;
  wire go = st_q == st_run && !stall;
  wire last = idx_q == 2'h2;
  wire cur_fire = fire_w[idx_q];
  wire cur_rem = rem_w[idx_q];
  wire rod_act_t cur_kind = kind_w[idx_q];
  wire cur_tmr = cur_kind == timer_action;
  wire tmr_stb = go && cur_fire && cur_tmr;
  wire tmr_start = cmd_w[idx_q][0];
  wire [3:0] tmr_idx = chan_w[idx_q];
  wire loc_go = go && cur_fire && !cur_tmr && !cur_rem;
  wire net_go = go && cur_fire && !cur_tmr && cur_rem;
  wire net_done = net_valid_q && net_ready;
  wire tick_wrap = tick_cnt_q == 32'(TICK_CYC - 1);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      en_q <= `ROD_CTRL_RST;
      slot_q <= '{default: `ROD_SLOT_RST};
      ip_q <= '{default: `ROD_IP_RST};
    end
    else
    begin
      if (wr_ctrl)
        en_q <= reg_wdata[0];
      if (reg_wr && slot_win)
        slot_q[win_idx] <= reg_wdata;
      if (reg_wr && ip_win)
        ip_q[win_idx] <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      rdata_q <= 32'h0000_0000;
    else
      rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= st_idle;
      idx_q <= 2'h0;
      res_q <= 1'b0;
      busy_q <= 1'b0;
    end
    else
    begin
      unique case (st_q)
        st_idle:
          if (accept)
          begin
            st_q <= st_run;
            idx_q <= 2'h0;
            res_q <= res_val;
            busy_q <= 1'b1;
          end
        st_run:
          if (go)
          begin
            idx_q <= last ? 2'h0 : idx_q + 2'h1;
            st_q <= last ? st_idle : st_run;
            busy_q <= !last;
          end
      endcase
    end
  end

  // local command port: one-cycle strobe per fired local slot that is not a timer
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      loc_stb_q <= 1'b0;
      loc_kind_q <= null_action;
      loc_chan_q <= 4'h0;
      loc_cmd_q <= 2'h0;
      loc_val_q <= 16'h0000;
      loc_range_q <= 3'h0;
    end
    else
    begin
      loc_stb_q <= loc_go;
      if (loc_go)
      begin
        loc_kind_q <= cur_kind;
        loc_chan_q <= chan_w[idx_q];
        loc_cmd_q <= cmd_w[idx_q];
        loc_val_q <= val_w[idx_q];
        loc_range_q <= rng_w[idx_q];
      end
    end
  end

  // link command: held until the link takes it
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      net_valid_q <= 1'b0;
      net_ip_q <= 32'h0000_0000;
      net_kind_q <= null_action;
      net_chan_q <= 4'h0;
      net_cmd_q <= 2'h0;
      net_val_q <= 16'h0000;
      net_range_q <= 3'h0;
    end
    else if (net_go)
    begin
      net_valid_q <= 1'b1;
      net_ip_q <= ip_q[ips_w[idx_q]];
      net_kind_q <= cur_kind;
      net_chan_q <= chan_w[idx_q];
      net_cmd_q <= cmd_w[idx_q];
      net_val_q <= val_w[idx_q];
      net_range_q <= rng_w[idx_q];
    end
    else if (net_done)
      net_valid_q <= 1'b0;
  end

  // shared timebase for the local timers
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_cnt_q <= tick_wrap ? 32'h0000_0000 : tick_cnt_q + 32'h1;
      tick_q <= tick_wrap;
    end
  end

  // timers saturate rather than wrap so a long delay never looks short
  for (genvar t = 0; t < N_TMR; t++)
  begin : g_tmr
    wire hit = tmr_stb && tmr_idx == 4'(t);
    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
      begin
        tmr_run_q[t] <= 1'b0;
        tmr_cnt_q[t] <= 16'h0000;
      end
      else if (hit && !tmr_start)
      begin
        tmr_run_q[t] <= 1'b0;
        tmr_cnt_q[t] <= 16'h0000;
      end
      else
      begin
        if (hit)
          tmr_run_q[t] <= 1'b1;
        if (tmr_run_q[t] && tick_q && tmr_cnt_q[t] != 16'hffff)
          tmr_cnt_q[t] <= tmr_cnt_q[t] + 16'h1;
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign busy = busy_q;
  assign loc_stb = loc_stb_q;
  assign loc_kind = loc_kind_q;
  assign loc_chan = loc_chan_q;
  assign loc_cmd = loc_cmd_q;
  assign loc_val = loc_val_q;
  assign loc_range = loc_range_q;
  assign net_valid = net_valid_q;
  assign net_ip = net_ip_q;
  assign net_kind = net_kind_q;
  assign net_chan = net_chan_q;
  assign net_cmd = net_cmd_q;
  assign net_val = net_val_q;
  assign net_range = net_range_q;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  slot_walk_a: assert property ((go && !last) |=> idx_q == $past(idx_q) + 2'h1 && busy_q)
    else $error("slot sequence skipped a slot");
  run_end_a: assert property ((go && last) |=> st_q == st_idle && !busy_q)
    else $error("run did not end after third slot");
  remote_route_a: assert property (net_go |=> net_valid_q && !loc_stb_q
    && net_ip_q == $past(ip_q[ips_w[idx_q]]))
    else $error("remote action not sent on link");
  local_route_a: assert property (loc_go |=> loc_stb_q && !$rose(net_valid_q))
    else $error("local action not applied locally");
  burst_len_a: assert property ((loc_go && cur_kind == pulse_out_action
    && cmd_w[idx_q] == `ROD_CMD_THIRD) |=> loc_val_q == $past(val_w[idx_q]))
    else $error("burst length differs from slot value");
  ao_range_a: assert property ((loc_go && cur_kind == analog_out_action)
    |=> loc_range_q == $past(rng_w[idx_q]) && loc_val_q == $past(val_w[idx_q]))
    else $error("analog value sent without its range");
  timer_clear_a: assert property ((tmr_stb && !tmr_start)
    |=> !tmr_run_q[$past(tmr_idx)] && tmr_cnt_q[$past(tmr_idx)] == 16'h0000)
    else $error("timer not stopped and cleared");
  timer_start_a: assert property ((tmr_stb && tmr_start) |=> tmr_run_q[$past(tmr_idx)])
    else $error("timer not started");
  link_hold_a: assert property (stall |=> net_valid_q && $stable(net_ip_q))
    else $error("link command dropped before taken");

  remote_seen_c: cover property (net_go ##1 stall ##1 net_done);
  burst_seen_c: cover property (loc_go && cur_kind == pulse_out_action);
  timer_seen_c: cover property (tmr_stb && tmr_start ##[1:200] tmr_stb && !tmr_start);
endmodule

//--- dv/rod_link_model.sv
`timescale 1ns/1ps
module rod_link_model
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic net_valid,
  output logic net_ready,
  output logic taken
);
  logic [7:0] sr_q;
  // random stalls, so the slot walk must wait on the link
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      sr_q <= 8'h5b;
      net_ready <= 1'b0;
    end
    else
    begin
      sr_q <= {sr_q[6:0], sr_q[7] ^ sr_q[5] ^ sr_q[4] ^ sr_q[3]};
      net_ready <= sr_q[0] | sr_q[2];
    end
  assign taken = net_valid & net_ready;
endmodule

//--- dv/tb_top.sv
`timescale 1ns/1ps
`include "rod_regs.svh"
module tb_top;
  import rod_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic res_stb = 1'b0;
  logic res_val = 1'b0;
  logic [31:0] reg_rdata, net_ip, d;
  logic busy, loc_stb, net_valid, net_ready, taken;
  rod_act_t loc_kind, net_kind;
  logic [3:0] loc_chan, net_chan;
  logic [1:0] loc_cmd, net_cmd;
  logic [15:0] loc_val, net_val;
  logic [2:0] loc_range, net_range;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  logic en_exp = 1'b0;
  logic [31:0] sr = 32'h711e;
  logic [31:0] ipt [4];
  logic [31:0] w [3];
  logic [31:0] cw [6] = '{32'h1234_5301, 32'h0007_0fac, 32'h0000_0983,
                          32'h0000_02c3, 32'hffff_fff6, 32'h0000_0007};
  logic [55:0] locq [$];
  logic [87:0] netq [$];
  logic [55:0] le;
  logic [87:0] ne;
  logic [56:0] x;
  wire [27:0] loc_ev = {loc_kind, loc_chan, loc_cmd, loc_val, loc_range};
  wire [27:0] net_ev = {net_kind, net_chan, net_cmd, net_val, net_range};

  rod_top #(.TICK_CYC(4)) u_rod_top (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .res_stb, .res_val, .busy, .loc_stb, .loc_kind, .loc_chan, .loc_cmd, .loc_val,
    .loc_range, .net_valid, .net_ready, .net_ip, .net_kind, .net_chan, .net_cmd, .net_val, .net_range);
  rod_link_model u_rod_link_model (.core_clk, .rst, .net_valid, .net_ready, .taken);

  always #2.5 core_clk = ~core_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // {fires, compare mask, expected action}; masked fields are free per kind
  function automatic logic [56:0] exp_act(input logic [31:0] v, input logic r);
    logic [1:0] t;
    logic [1:0] c;
    logic f;
    logic [27:0] m;
    t = v[7:6];
    c = t;
    f = 1'b0;
    m = 28'hff8_0000;
    case (v[2:0])
      3'h1: {f, m} = {r, 28'hfe7_ffff};
      3'h2: {f, m, c} = {1'b1, 28'hfe8_0000, 1'b0, t[0] ~^ r};
      3'h3: {f, c} = r ? {t != 2'h3, t} : {t < 2'h2, 1'b0, ~t[0]};
      3'h4: {f, m} = {r && t != 2'h3, t == 2'h2 ? 28'hfff_fff8 : 28'hff8_0000};
      default: f = 1'b0;
    endcase
    return {f, m, v[2:0], v[11:8], c, v[31:16], v[14:12]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task print_verdict;
    if (bad_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task rc(input logic [7:0] a, input logic [31:0] v);
    rd(a);
    chk(d, v);
  endtask

  // second strobe lands while busy and must be dropped
  task fire(input logic r);
    @(posedge core_clk);
    res_stb <= 1'b1;
    res_val <= r;
    @(posedge core_clk);
    res_stb <= 1'b0;
    @(posedge core_clk);
    chk({31'h0, busy}, {31'h0, en_exp});
    res_stb <= 1'b1;
    res_val <= ~r;
    @(posedge core_clk);
    res_stb <= 1'b0;
    for (int k = 0; k < 300 && (busy | net_valid) !== 1'b0; k++)
      @(posedge core_clk) #1;
    // last slot's strobe is seen one edge after busy falls
    @(posedge core_clk) #1;
    chk(32'(locq.size() + netq.size()), 32'h0);
  endtask

  task run(input logic r);
    for (int s = 0; s < 3; s++)
    begin
      wr(`ROD_SLOT0 + 8'(4 * s), w[s]);
      x = exp_act(w[s], r);
      if (x[56] && w[s][3])
        netq.push_back({ipt[w[s][5:4]], x[55:0]});
      else if (x[56])
        locq.push_back(x[55:0]);
    end
    fire(r);
  endtask

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      bad_count++;
      print_verdict;
    end
    if (loc_stb)
    begin
      le = locq.size() > 0 ? locq.pop_front() : '1;
      chk({4'h0, le[55:28] & loc_ev}, {4'h0, le[55:28] & le[27:0]});
    end
    if (taken)
    begin
      ne = netq.size() > 0 ? netq.pop_front() : '1;
      chk(net_ip, ne[87:56]);
      chk({4'h0, ne[55:28] & net_ev}, {4'h0, ne[55:28] & ne[27:0]});
    end
  end

  initial
  begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    rc(`ROD_CTRL, 32'h0);
    rc(`ROD_SLOT0 + 8'h8, `ROD_SLOT_RST);
    rc(8'h0c, 32'h0);
    wr(`ROD_STAT, 32'hffff_ffff);
    rc(`ROD_STAT, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      sr = lfsr(sr);
      ipt[i] = sr;
      wr(`ROD_IP0 + 8'(4 * i), sr);
      rc(`ROD_IP0 + 8'(4 * i), sr);
    end
    // disabled: strobe ignored, nothing queued
    wr(`ROD_SLOT0, 32'h0000_0002);
    fire(1'b1);
    wr(`ROD_CTRL, 32'h1);
    en_exp = 1'b1;
    w = '{32'h0000_0f05, 32'h0, 32'h0};
    run(1'b1);
    repeat (40) @(posedge core_clk);
    rd(`ROD_TMR0 + 8'h3c);
    chk({31'h0, d[15:0] != 16'h0}, 32'h1);
    rc(`ROD_TMR0, 32'h0);
    rd(`ROD_TRUN);
    chk({31'h0, d[15]}, 32'h1);
    run(1'b0);
    rc(`ROD_TMR0 + 8'h3c, 32'h0);
    w[0] = 32'h0000_0f45;
    run(1'b0);
    repeat (40) @(posedge core_clk);
    rd(`ROD_TMR0 + 8'h3c);
    chk({31'h0, d[15:0] != 16'h0}, 32'h1);
    run(1'b1);
    rc(`ROD_TMR0 + 8'h3c, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      w = '{cw[3 * (i % 2)], cw[3 * (i % 2) + 1], cw[3 * (i % 2) + 2]};
      run(i[1]);
    end
    for (int i = 0; i < 60; i++)
    begin
      for (int s = 0; s < 3; s++)
      begin
        sr = lfsr(sr);
        w[s] = sr;
      end
      run(sr[9]);
    end
    print_verdict;
  end
endmodule
